// File: include/palette_pixel_pkg.sv
// Overview of operation
// RL1: after reset the block runs legacy pass-through, mode 0, from the legacy port.
// RL2: selecting pass-through restores clock select, general control and read mask defaults.
// RL3: pass-through is timed by oscillator input zero; normal modes by the shift clock.
// RL4: normal modes take 8, 16 or 32 bit buses; modes 1-3 also 4 bits.
// RL5: the source drives the low pixel lines and grounds the unused ones.
// RL6: mode 1 pixel bit is address bit 0; page register gives bits 7..1.
// RL7: mode 1 multiplexes up to 32 one-bit pixels per load.
// RL8: mode 2 pixels give address bits 1..0, page bits 7..2, up to 16 per load.
// RL9: mode 3 pixels give address bits 3..0, page bits 7..4, 1 to 8 per load.
// RL10: mode 4 takes all eight address bits from the bus, ignoring the page register.
// RL11: mode 5 true colour gets the same delay as overlay, blank and sync.
// RL12: mode 5 low byte is overlay; zero byte or zero mask shows no overlay.
// RL13: true colour stays 8 bits per colour; overlay width follows the width select pin.
// RL14: mode 5 bits 15..8 go red, 23..16 green, 31..24 blue.
// RL15: nibble mode bit set and split transfer bit clear overrides the mux setting.
// RL16: nibble mode builds 16 bits from one nibble of each of four bytes.
// RL17: nibble mode pixels give address bits 3..0, page bits 7..4.
// RL18: mux register bits 5..0 select mode and width per the mode table.
// RL19: nibble flag low takes low nibbles, high takes high nibbles, lowest byte first.
// RL20: a shift clock rise latches the whole bus; dot clocks shift out low group first.
// RL21: software programs the shift clock divide ratio itself to match mode and width.
// RL22: writing 2Dh to mux bits 5..0 resets all registers to pass-through defaults.
// RL23: each load yields exactly width over bits-per-pixel pixels, one per dot clock.
package palette_pixel_pkg;
  localparam int PIX_W = 32;
  localparam logic [2:0] REG_MUX = 3'h0;
  localparam logic [2:0] REG_GCTL = 3'h1;
  localparam logic [2:0] REG_MASK = 3'h2;
  localparam logic [2:0] REG_PAGE = 3'h3;
  localparam logic [2:0] REG_CLKSEL = 3'h4;
  localparam logic [2:0] REG_STATUS = 3'h5;
  localparam logic [7:0] MUX_RST = 8'h2D;
  localparam logic [7:0] GCTL_RST = 8'h03;
  localparam logic [7:0] MASK_RST = 8'hFF;
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [7:0] CLKSEL_RST = 8'h3F;
  localparam logic [5:0] MUX_PASS = 6'h2D;
  localparam logic [3:0] MUX_GRP_ONE = 4'h4;
  localparam logic [3:0] MUX_GRP_TWO = 4'h5;
  localparam logic [3:0] MUX_GRP_THREE = 4'h6;
  localparam logic [5:0] MUX_FOUR_8 = 6'h1C;
  localparam logic [5:0] MUX_FOUR_16 = 6'h1D;
  localparam logic [5:0] MUX_FOUR_32 = 6'h1E;
  localparam logic [5:0] MUX_TRUE = 6'h0D;
  localparam int GCTL_NIB_BIT = 3;
  localparam int GCTL_SPLIT_BIT = 2;
  localparam int PIN_OSC = 0;
  localparam int PIN_SHIFT = 1;
  localparam int PIN_DOT = 2;
  localparam int PIN_NIBBLE_SELECT_FLAG = 3;
  localparam int PIN_WIDE = 4;
  localparam int PIN_BLANK = 5;
  localparam int PIN_SYNC = 6;
  localparam int PIN_N = 7;
  typedef enum logic [2:0] {
    MODE_PASS = 3'h0, MODE_ONE = 3'h1, MODE_TWO = 3'h3, MODE_THREE = 3'h2,
    MODE_FOUR = 3'h6, MODE_TRUE = 3'h7, MODE_NIB = 3'h5, MODE_OFF = 3'h4
  } mode_t;
  typedef enum logic [1:0] {ST_WAIT = 2'h0, ST_SHIFT = 2'h1, ST_PASS = 2'h3} phase_t;
  typedef struct packed {
    mode_t mode;
    logic [3:0] bpp;
    logic [5:0] npix;
    logic [7:0] lowmask;
  } mode_cfg_t;
endpackage

// File: design/palette_pixel_mode_mux.sv
module palette_pixel_mode_mux
  import palette_pixel_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CE,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic [PIX_W-1:0] PIXEL_PORT,
  input wire logic [7:0] LEGACY_PORT,
  input wire logic SHIFT_CLOCK,
  input wire logic DOT_CLOCK,
  input wire logic OSCILLATOR_INPUT_ZERO,
  input wire logic NIBBLE_FLAG_INPUT,
  input wire logic WIDTH_SELECT_8,
  input wire logic BLANK_IN_B,
  input wire logic SYNC_IN_B,
  output logic [7:0] PALETTE_ADDR,
  output logic PIXEL_VALID,
  output logic OVERLAY_ACTIVE,
  output logic TRUE_COLOR_ON,
  output logic [7:0] TRUE_RED,
  output logic [7:0] TRUE_GREEN,
  output logic [7:0] TRUE_BLUE,
  output logic PALETTE_WIDE,
  output logic BLANK_OUT_B,
  output logic SYNC_OUT_B
);

  typedef struct packed {
    logic [PIN_N-1:0] s1;
    logic [PIN_N-1:0] s2;
    logic [PIN_N-1:0] s3;
    logic [PIN_N-1:0] filt;
    logic [PIX_W-1:0] p1;
    logic [PIX_W-1:0] p2;
    logic [PIX_W-1:0] p3;
    logic [7:0] v1;
    logic [7:0] v2;
    logic [7:0] v3;
    logic [7:0] mux;
    logic [7:0] gctl;
    logic [7:0] mask;
    logic [7:0] page;
    logic [7:0] clksel;
    phase_t phase;
    mode_t cur;
    logic [PIX_W-1:0] word;
    logic [5:0] remain;
    logic [3:0] bpp;
    logic [7:0] lowmask;
    logic [7:0] rdata;
    logic [7:0] addr;
    logic valid;
    logic overlay;
    logic tc;
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
    logic wide;
    logic blank_b;
    logic sync_b;
  } state_t;

  state_t st;
  state_t next_st;
  logic [PIN_N-1:0] agree;
  logic [PIN_N-1:0] rise;
  logic nib_on;
  mode_cfg_t cfg;

  // mode table lookup; nibble mode wins over the mux field
  function automatic mode_cfg_t decode_mode(input logic [5:0] mux, input logic nib);
    mode_cfg_t c;
    logic [5:0] wpix;
    c = '{MODE_OFF, 4'h8, 6'h01, 8'hFF};
    wpix = 6'h04 << mux[1:0];
    if (nib) begin
      c = '{MODE_NIB, 4'h4, 6'h04, 8'h0F}; // RL15 RL16 RL17
    end else if (mux == MUX_PASS) begin
      c = '{MODE_PASS, 4'h8, 6'h01, 8'hFF}; // RL18
    end else if (mux[5:2] == MUX_GRP_ONE) begin
      c = '{MODE_ONE, 4'h1, wpix, 8'h01}; // RL4 RL7 RL18
    end else if (mux[5:2] == MUX_GRP_TWO) begin
      c = '{MODE_TWO, 4'h2, wpix >> 1, 8'h03}; // RL8
    end else if (mux[5:2] == MUX_GRP_THREE) begin
      c = '{MODE_THREE, 4'h4, wpix >> 2, 8'h0F}; // RL9
    end else if (mux == MUX_FOUR_8) begin
      c = '{MODE_FOUR, 4'h8, 6'h01, 8'hFF}; // RL10
    end else if (mux == MUX_FOUR_16) begin
      c = '{MODE_FOUR, 4'h8, 6'h02, 8'hFF}; // RL10
    end else if (mux == MUX_FOUR_32) begin
      c = '{MODE_FOUR, 4'h8, 6'h04, 8'hFF}; // RL10
    end else if (mux == MUX_TRUE) begin
      c = '{MODE_TRUE, 4'h8, 6'h01, 8'hFF}; // RL11
    end
    return c;
  endfunction

  // one nibble of each byte, lowest byte first, packed into the low 16 bits
  function automatic logic [PIX_W-1:0] nibble_pack(input logic [PIX_W-1:0] w, input logic hi);
    logic [PIX_W-1:0] r;
    r = '0;
    for (int k = 0; k < 4; k++) begin
      r[4*k +: 4] = hi ? w[8*k+4 +: 4] : w[8*k +: 4]; // RL16 RL19
    end
    return r;
  endfunction

  assign nib_on = st.gctl[GCTL_NIB_BIT] && !st.gctl[GCTL_SPLIT_BIT]; // RL15
  assign cfg = decode_mode(st.mux[5:0], nib_on);

  always_comb begin
    next_st = st;
    next_st.s1 = {SYNC_IN_B, BLANK_IN_B, WIDTH_SELECT_8, NIBBLE_FLAG_INPUT,
                  DOT_CLOCK, SHIFT_CLOCK, OSCILLATOR_INPUT_ZERO};
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // a pin level counts only once stages two and three agree
    agree = ~(st.s2 ^ st.s3);
    next_st.filt = (st.filt & ~agree) | (st.s2 & agree);
    rise = next_st.filt & ~st.filt;
    next_st.p1 = PIXEL_PORT;
    next_st.p2 = st.p1;
    next_st.p3 = st.p2;
    next_st.v1 = LEGACY_PORT;
    next_st.v2 = st.v1;
    next_st.v3 = st.v2;
    next_st.wide = st.filt[PIN_WIDE]; // RL13
    next_st.valid = 1'b0;
    next_st.rdata = '0;
    if (RD) begin
      case (ADDR)
        REG_MUX: next_st.rdata = st.mux;
        REG_GCTL: next_st.rdata = st.gctl;
        REG_MASK: next_st.rdata = st.mask;
        REG_PAGE: next_st.rdata = st.page;
        REG_CLKSEL: next_st.rdata = st.clksel;
        REG_STATUS: next_st.rdata = {st.phase, st.cur, 3'h0};
        default: next_st.rdata = '0;
      endcase
    end
    if (cfg.mode != st.cur) begin
      // mode change drops any pixels still held from the old mode
      next_st.cur = cfg.mode;
      next_st.phase = (cfg.mode == MODE_PASS) ? ST_PASS : ST_WAIT; // RL1 RL3
      next_st.remain = '0;
      next_st.tc = 1'b0;
      next_st.overlay = 1'b0;
    end else if (st.phase == ST_PASS) begin
      if (rise[PIN_OSC]) begin // RL3
        next_st.addr = st.v3 & st.mask; // RL1
        next_st.valid = 1'b1;
        next_st.blank_b = st.filt[PIN_BLANK];
        next_st.sync_b = st.filt[PIN_SYNC];
      end
    end else if (st.cur != MODE_OFF && rise[PIN_SHIFT]) begin
      // load wins over a dot edge in the same cycle
      next_st.word = (st.cur == MODE_NIB) ? nibble_pack(st.p3, st.filt[PIN_NIBBLE_SELECT_FLAG]) : st.p3; // RL20 RL16
      next_st.remain = cfg.npix; // RL23
      next_st.bpp = cfg.bpp;
      next_st.lowmask = cfg.lowmask;
      next_st.phase = ST_SHIFT;
    end else if (st.phase == ST_SHIFT && rise[PIN_DOT]) begin
      next_st.valid = 1'b1;
      next_st.blank_b = st.filt[PIN_BLANK]; // RL11
      next_st.sync_b = st.filt[PIN_SYNC]; // RL11
      if (st.cur == MODE_TRUE) begin
        next_st.addr = st.word[7:0] & st.mask; // RL12
        next_st.overlay = (st.word[7:0] != 8'h00) && (st.mask != 8'h00); // RL12
        next_st.tc = 1'b1;
        next_st.red = st.word[15:8]; // RL14 RL13
        next_st.green = st.word[23:16]; // RL14
        next_st.blue = st.word[31:24]; // RL14
      end else begin
        // low bits from the bus, the rest from the page register
        next_st.addr = ((st.page & ~st.lowmask) | (st.word[7:0] & st.lowmask)) & st.mask; // RL6 RL8 RL9 RL10 RL17
        next_st.overlay = 1'b0;
        next_st.tc = 1'b0;
      end
      next_st.word = st.word >> st.bpp; // RL20
      next_st.remain = st.remain - 6'h01; // RL23
      if (st.remain == 6'h01) begin
        next_st.phase = ST_WAIT; // RL23
      end
    end
    if (WR) begin
      case (ADDR)
        REG_MUX: begin
          next_st.mux = WDATA; // RL18
          if (WDATA[5:0] == MUX_PASS) begin
            next_st.gctl = GCTL_RST; // RL2 RL22
            next_st.mask = MASK_RST; // RL2 RL22
            next_st.page = PAGE_RST; // RL22
            next_st.clksel = CLKSEL_RST; // RL2 RL22
          end
        end
        REG_GCTL: next_st.gctl = WDATA;
        REG_MASK: next_st.mask = WDATA;
        REG_PAGE: next_st.page = WDATA;
        REG_CLKSEL: next_st.clksel = WDATA; // RL21
        default: next_st.mux = st.mux;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      st <= '0;
      st.mux <= MUX_RST; // RL1
      st.gctl <= GCTL_RST;
      st.mask <= MASK_RST;
      st.page <= PAGE_RST;
      st.clksel <= CLKSEL_RST;
      st.phase <= ST_PASS; // RL1
      st.cur <= MODE_PASS;
      st.blank_b <= 1'b1;
      st.sync_b <= 1'b1;
      // active-low pins idle high, so the filter starts at their idle level
      st.s1[PIN_BLANK] <= 1'b1;
      st.s1[PIN_SYNC] <= 1'b1;
      st.s2[PIN_BLANK] <= 1'b1;
      st.s2[PIN_SYNC] <= 1'b1;
      st.s3[PIN_BLANK] <= 1'b1;
      st.s3[PIN_SYNC] <= 1'b1;
      st.filt[PIN_BLANK] <= 1'b1;
      st.filt[PIN_SYNC] <= 1'b1;
    end else if (CE) begin
      st <= next_st;
    end
  end

  assign RDATA = st.rdata;
  assign PALETTE_ADDR = st.addr;
  assign PIXEL_VALID = st.valid;
  assign OVERLAY_ACTIVE = st.overlay;
  assign TRUE_COLOR_ON = st.tc;
  assign TRUE_RED = st.red;
  assign TRUE_GREEN = st.green;
  assign TRUE_BLUE = st.blue;
  assign PALETTE_WIDE = st.wide;
  assign BLANK_OUT_B = st.blank_b;
  assign SYNC_OUT_B = st.sync_b;

  // pixels given out since the last load, for checking only
  logic [6:0] emit_cnt;
  logic [5:0] load_n;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      emit_cnt <= '0;
      load_n <= '0;
    end else if (CE && st.phase != ST_PASS && st.cur == cfg.mode && st.cur != MODE_OFF && rise[PIN_SHIFT]) begin
      emit_cnt <= '0;
      load_n <= cfg.npix;
    end else if (CE && st.phase == ST_SHIFT && rise[PIN_DOT] && st.cur == cfg.mode) begin
      emit_cnt <= emit_cnt + 7'h01;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  sequence s_pass_write;
    CE && WR && ADDR == REG_MUX && WDATA[5:0] == MUX_PASS;
  endsequence
  sequence s_emit;
    PIXEL_VALID && $past(CE) && $past(st.phase) == ST_SHIFT;
  endsequence

  a_soft_reset_regs: assert property (s_pass_write |=> st.gctl == GCTL_RST && st.mask == MASK_RST // RL22
    && st.page == PAGE_RST && st.clksel == CLKSEL_RST) else $error("pass-through write left registers set");
  a_pass_defaults: assert property (s_pass_write |=> st.mask == MASK_RST && !nib_on) // RL2
    else $error("pass-through select kept mask or nibble mode");
  a_pass_mode_entry: assert property (s_pass_write ##1 CE |=> st.cur == MODE_PASS && st.phase == ST_PASS) // RL1
    else $error("pass-through not entered");
  a_pass_osc_timing: assert property (PIXEL_VALID && $past(CE) && $past(st.phase) == ST_PASS // RL3
    |-> $past(rise[PIN_OSC])) else $error("pass-through pixel without oscillator edge");
  a_nibble_override: assert property (CE && !WR && nib_on |=> st.cur == MODE_NIB) // RL15
    else $error("nibble mode did not override mux setting");
  a_shift_latch: assert property (CE && st.phase != ST_PASS && st.cur == cfg.mode && st.cur != MODE_OFF
    && rise[PIN_SHIFT] |=> st.phase == ST_SHIFT && st.remain == $past(cfg.npix)) // RL20
    else $error("shift clock load not taken");
  a_load_count: assert property (emit_cnt <= {1'b0, load_n}) // RL23
    else $error("more pixels than one load holds");
  a_mode1_page: assert property (s_emit and $past(st.cur) == MODE_ONE // RL6
    |-> PALETTE_ADDR[7:1] == $past(st.page[7:1] & st.mask[7:1])) else $error("mode 1 upper bits not page");
  a_mode4_nopage: assert property (s_emit and $past(st.cur) == MODE_FOUR // RL10
    |-> PALETTE_ADDR == $past(st.word[7:0] & st.mask)) else $error("mode 4 address not from bus");
  a_true_rgb: assert property (s_emit and $past(st.cur) == MODE_TRUE |-> TRUE_RED == $past(st.word[15:8]) // RL14
    && TRUE_GREEN == $past(st.word[23:16]) && TRUE_BLUE == $past(st.word[31:24])) else $error("true colour lanes");
  a_overlay_mask: assert property (s_emit and $past(st.cur) == MODE_TRUE and $past(st.mask) == 8'h00 // RL12
    |-> !OVERLAY_ACTIVE) else $error("overlay shown with zero mask");
  a_read_back: assert property (CE && RD && ADDR == REG_MUX |=> RDATA == $past(st.mux)) // RL18
    else $error("mux register read back wrong");
  a_mode2_page: assert property (s_emit and $past(st.cur) == MODE_TWO // RL8
    |-> PALETTE_ADDR[7:2] == $past(st.page[7:2] & st.mask[7:2])) else $error("mode 2 upper bits not page");
  a_mode3_page: assert property (s_emit and $past(st.cur) == MODE_THREE // RL9
    |-> PALETTE_ADDR[7:4] == $past(st.page[7:4] & st.mask[7:4])) else $error("mode 3 upper bits not page");
  a_nibble_addr: assert property (s_emit and $past(st.cur) == MODE_NIB // RL17
    |-> PALETTE_ADDR == $past({st.page[7:4], st.word[3:0]} & st.mask)) else $error("nibble mode address wrong");
  a_overlay_zero: assert property (s_emit and $past(st.cur) == MODE_TRUE // RL12
    and $past(st.word[7:0]) == 8'h00 |-> !OVERLAY_ACTIVE) else $error("overlay shown for zero byte");
  a_ctl_delay: assert property (s_emit |-> BLANK_OUT_B == $past(st.filt[PIN_BLANK]) // RL11
    && SYNC_OUT_B == $past(st.filt[PIN_SYNC])) else $error("blank or sync out of step with pixel");
  a_pass_addr: assert property (PIXEL_VALID && $past(CE) && $past(st.phase) == ST_PASS // RL1
    |-> PALETTE_ADDR == $past(st.v3 & st.mask)) else $error("pass-through address wrong");
  a_rdata_idle: assert property (CE && !RD |=> RDATA == 8'h00) // RL18
    else $error("read data stood without a read");

endmodule

// File: test/frame_source.sv
module frame_source (
  input wire logic clk,
  output logic [31:0] pixel_port,
  output logic [7:0] legacy_port,
  output logic shift_clock,
  output logic dot_clock,
  output logic osc_zero
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    pixel_port = '0;
    legacy_port = '0;
    shift_clock = 1'b0;
    dot_clock = 1'b0;
    osc_zero = 1'b0;
  end
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // pins stay at least 4 cycles per level (shift clock 6 high), above the 2-cycle minimum
  task automatic burst(input logic [31:0] w, input int ndot);
    pixel_port <= w;
    idle(4);
    shift_clock <= 1'b1;
    idle(6);
    shift_clock <= 1'b0;
    // released bus never shows the word that was loaded
    pixel_port <= ~w;
    idle(4);
    repeat (ndot) begin
      dot_clock <= 1'b1;
      idle(4);
      dot_clock <= 1'b0;
      idle(4);
    end
  endtask
  task automatic pass_pixel(input logic [7:0] v);
    legacy_port <= v;
    idle(4);
    osc_zero <= 1'b1;
    idle(4);
    osc_zero <= 1'b0;
    legacy_port <= ~v;
    idle(4);
  endtask
endmodule

// File: test/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import palette_pixel_pkg::*;
  logic CLK, RST_B, CE, WR, RD, NIBBLE_SELECT_FLAG, WIDE, BLANK_B, SYNC_B, SHIFT, DOT, OSC;
  logic OVL, TC_ON, PWIDE, BLANK_O, SYNC_O, VALID;
  logic [2:0] ADDR;
  logic [7:0] WDATA, RDATA, PADDR, RED, GREEN, BLUE, LEGACY;
  logic [31:0] PIX;
  logic [7:0] q[$];
  logic [23:0] last_col;
  logic [1:0] last_ctl;
  logic last_ovl;
  int n_fail = 0;
  int n_tests = 0;

  palette_pixel_mode_mux palette_pixel_mode_mux_inst (.CLK(CLK), .RST_B(RST_B), .CE(CE),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .PIXEL_PORT(PIX),
    .LEGACY_PORT(LEGACY), .SHIFT_CLOCK(SHIFT), .DOT_CLOCK(DOT), .OSCILLATOR_INPUT_ZERO(OSC),
    .NIBBLE_FLAG_INPUT(NIBBLE_SELECT_FLAG), .WIDTH_SELECT_8(WIDE), .BLANK_IN_B(BLANK_B), .SYNC_IN_B(SYNC_B),
    .PALETTE_ADDR(PADDR), .PIXEL_VALID(VALID), .OVERLAY_ACTIVE(OVL), .TRUE_COLOR_ON(TC_ON),
    .TRUE_RED(RED), .TRUE_GREEN(GREEN), .TRUE_BLUE(BLUE), .PALETTE_WIDE(PWIDE),
    .BLANK_OUT_B(BLANK_O), .SYNC_OUT_B(SYNC_O));
  frame_source frame_source_inst (.clk(CLK), .pixel_port(PIX), .legacy_port(LEGACY),
    .shift_clock(SHIFT), .dot_clock(DOT), .osc_zero(OSC));

  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  // record every emitted pixel address; keep the side outputs of the last one only
  always @(posedge CLK) begin
    if (VALID === 1'b1) begin
      q.push_back(PADDR);
      last_col <= {BLUE, GREEN, RED};
      last_ovl <= OVL;
      last_ctl <= {BLANK_O, SYNC_O};
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    @(negedge CLK);
    chk(RDATA, e, "register read");
  endtask
  task automatic expect_pix(input logic [7:0] e[$]);
    repeat (8) @(posedge CLK);
    chk(q.size(), e.size(), "pixel count");
    foreach (e[i]) if (i < q.size()) chk(q[i], e[i], "palette address");
    q.delete();
  endtask
  task automatic read_defaults;
    rd(REG_MUX, 8'h2D);
    rd(REG_GCTL, 8'h03);
    rd(REG_MASK, 8'hFF);
    rd(REG_PAGE, 8'h00);
    rd(REG_CLKSEL, 8'h3F);
  endtask

  task automatic t_reset;
    read_defaults();
    wr(3'h6, 8'h55);
    rd(3'h6, 8'h00);
    frame_source_inst.pass_pixel(8'h5A);
    frame_source_inst.pass_pixel(8'hC3);
    frame_source_inst.burst(32'h000000FF, 2);
    expect_pix({8'h5A, 8'hC3});
    $display("test reset and pass-through done");
  endtask
  task automatic t_modes;
    int bpp, wid, n;
    logic [31:0] w;
    logic [7:0] lm;
    logic [7:0] e[$];
    wr(REG_PAGE, 8'hA5);
    for (int c = 8'h10; c <= 8'h1E; c++) begin
      bpp = 1 << c[3:2];
      wid = (c[3:2] == 3) ? (8 << c[1:0]) : (4 << c[1:0]);
      n = wid / bpp;
      lm = 8'((1 << bpp) - 1);
      w = 32'h9E3B6C5D & 32'((33'h1 << wid) - 1);
      e = {};
      for (int i = 0; i < n; i++) e.push_back((8'hA5 & ~lm) | (8'(w >> (i * bpp)) & lm));
      wr(REG_MUX, 8'(c));
      frame_source_inst.burst(w, n + 1);
      expect_pix(e);
    end
    chk(TC_ON, 1'b0, "true colour flag off");
    wr(REG_MUX, 8'h00);
    e = {};
    frame_source_inst.burst(32'h000000FF, 2);
    expect_pix(e);
    $display("test mode table done");
  endtask
  task automatic t_true;
    wr(REG_MUX, 8'h0D);
    WIDE <= 1'b1;
    BLANK_B <= 1'b0;
    frame_source_inst.burst(32'h345678C1, 2);
    expect_pix({8'hC1});
    chk(last_ovl, 1'b1, "overlay on");
    chk(last_col, 24'h345678, "colour lanes");
    chk(last_ctl, 2'b01, "blank and sync");
    chk(PWIDE, 1'b1, "width select");
    chk(TC_ON, 1'b1, "true colour flag");
    BLANK_B <= 1'b1;
    SYNC_B <= 1'b0;
    frame_source_inst.burst(32'h34567800, 1);
    expect_pix({8'h00});
    chk(last_ovl, 1'b0, "overlay zero byte");
    chk(last_ctl, 2'b10, "blank and sync");
    wr(REG_MASK, 8'h00);
    frame_source_inst.burst(32'h345678C1, 1);
    expect_pix({8'h00});
    chk(last_ovl, 1'b0, "overlay zero mask");
    wr(REG_MASK, 8'hFF);
    SYNC_B <= 1'b1;
    WIDE <= 1'b0;
    $display("test true colour done");
  endtask
  task automatic t_nibble;
    wr(REG_GCTL, 8'h08);
    NIBBLE_SELECT_FLAG <= 1'b0;
    frame_source_inst.burst(32'hF1E2D3C4, 5);
    expect_pix({8'hA4, 8'hA3, 8'hA2, 8'hA1});
    NIBBLE_SELECT_FLAG <= 1'b1;
    frame_source_inst.burst(32'hF1E2D3C4, 5);
    expect_pix({8'hAC, 8'hAD, 8'hAE, 8'hAF});
    rd(REG_STATUS, 8'h28);
    wr(REG_GCTL, 8'h0C);
    frame_source_inst.burst(32'hF1E2D3C4, 2);
    expect_pix({8'hC4});
    $display("test nibble mode done");
  endtask
  task automatic t_soft;
    wr(REG_MASK, 8'h0F);
    wr(REG_PAGE, 8'h33);
    wr(REG_CLKSEL, 8'h12);
    wr(REG_GCTL, 8'h08);
    wr(REG_MUX, 8'h2D);
    read_defaults();
    frame_source_inst.pass_pixel(8'h96);
    expect_pix({8'h96});
    rd(REG_STATUS, 8'hC0);
    CE <= 1'b0;
    wr(REG_PAGE, 8'h77);
    CE <= 1'b1;
    rd(REG_PAGE, 8'h00);
    $display("test software reset done");
  endtask

  task automatic print_verdict;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge CLK);
    n_fail++;
    $display("ERROR %0t watchdog expired", $time);
    print_verdict();
  end
  initial begin
    RST_B = 1'b0;
    WR = 1'b0;
    RD = 1'b0;
    CE = 1'b1;
    ADDR = '0;
    WDATA = '0;
    NIBBLE_SELECT_FLAG = 1'b0;
    WIDE = 1'b0;
    BLANK_B = 1'b1;
    SYNC_B = 1'b1;
    repeat (3) @(posedge CLK);
    RST_B <= 1'b1;
    t_reset();
    t_modes();
    t_true();
    t_nibble();
    t_soft();
    print_verdict();
  end
endmodule
